// file: dv/porb_host_model.sv
// host side of the register port: single-byte writes and reads
`timescale 1ns/1ps
module porb_host_model (
    input  wire       core_clk,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata
);
    // ==========================================================
    // bus tasks, entered just after a rising edge
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // at a pending offset a one in d clears that pending flag, a zero leaves it alone
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr = a;
            reg_wr = 1'b1;
            reg_wdata = d;
            @(posedge core_clk);
            #1;
            reg_wr = 1'b0;
            reg_wdata = ~d; // released data inverted so a stale value never passes
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            reg_addr = a;
            @(posedge core_clk);
            #1;
            d = reg_rdata;
        end
    endtask
endmodule

// file: dv/porb_regs_props.sv
// concurrent checks on the power and interrupt bank ports
`timescale 1ns/1ps
`include "porb_defines.vh"
module porb_regs_props (
    input wire       core_clk,
    input wire       rst_n,
    input wire       clk_en,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       pm_dac_pwr,
    input wire       converter_pwr,
    input wire       monitor_adc_pwr,
    input wire       dc_bias_pwr,
    input wire       line_circuit_pwr,
    input wire       adc_pwr,
    input wire       dac_pwr,
    input wire       gm_amp_pwr
);
    // ==========================================================
    // write decode: power outputs settle two edges after the write
    // a strobe seen while the clock enable is low is dropped by the bank
    wire wa = clk_en && reg_wr && (reg_addr == `PORB_OFS_PWR_A);
    wire wb = clk_en && reg_wr && (reg_addr == `PORB_OFS_PWR_B);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_pm_force_on: assert property (wa && reg_wdata[5] |-> ##2 pm_dac_pwr)
        else $error("pm dac not forced on");
    a_conv_force_off: assert property (wa && reg_wdata[4] |-> ##2 !converter_pwr)
        else $error("converter not forced off");
    a_mon_force_off: assert property (wa && reg_wdata[3] |-> ##2 !monitor_adc_pwr)
        else $error("monitor adc not forced off");
    a_bias_force_off: assert property (wa && reg_wdata[1] |-> ##2 !dc_bias_pwr)
        else $error("dc bias not forced off");
    a_line_force_off: assert property (wa && reg_wdata[0] |-> ##2 !line_circuit_pwr)
        else $error("line circuit not forced off");
    a_adc_manual_off: assert property (wb && reg_wdata[5:4] == 2'b10 |-> ##2 !adc_pwr)
        else $error("adc not off in manual");
    a_dac_manual_on: assert property (wb && reg_wdata[3:2] == 2'b11 |-> ##2 dac_pwr)
        else $error("dac not on in manual");
    a_gm_manual_on: assert property (wb && reg_wdata[1:0] == 2'b11 |-> ##2 gm_amp_pwr)
        else $error("gm amp not on in manual");
endmodule
bind porb_regs porb_regs_props chk_u (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
    .pm_dac_pwr, .converter_pwr, .monitor_adc_pwr, .dc_bias_pwr, .line_circuit_pwr,
    .adc_pwr, .dac_pwr, .gm_amp_pwr);

// file: dv/testbench.sv
// self-checking bench for the power and interrupt bank
`timescale 1ns/1ps
module testbench;
    reg        core_clk = 1'b0;
    reg        rst_n    = 1'b0;
    reg        clk_en   = 1'b1;
    wire [7:0] nc_rdata;
    wire       nc_conv;
    reg  [7:0] auto_on  = 8'h00;
    reg  [7:0] ev_t     = 8'h00;
    reg  [7:0] ev_l     = 8'h00;
    reg  [7:0] rd_val;
    wire [7:0] reg_addr;
    wire       reg_wr;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire [7:0] pwr;
    wire       irq_out;
    integer    fail_count = 0;
    integer    compares   = 0;
    always #2.5 core_clk = ~core_clk;
    porb_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // clock enable driven by the bench so the freeze path is exercised
    porb_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pm_dac_auto_on(auto_on[7]), .converter_auto_on(auto_on[6]),
        .monitor_adc_auto_on(auto_on[5]), .dc_bias_auto_on(auto_on[4]),
        .line_circuit_auto_on(auto_on[3]), .adc_auto_on(auto_on[2]), .dac_auto_on(auto_on[1]),
        .gm_amp_auto_on(auto_on[0]), .timer_events(ev_t), .line_alarm_events(ev_l),
        .pm_dac_pwr(pwr[7]), .converter_pwr(pwr[6]), .monitor_adc_pwr(pwr[5]),
        .dc_bias_pwr(pwr[4]), .line_circuit_pwr(pwr[3]), .adc_pwr(pwr[2]), .dac_pwr(pwr[1]),
        .gm_amp_pwr(pwr[0]), .irq_out(irq_out));
    // converterless variant shares the bus; only its read data and converter are judged
    porb_regs #(.HAS_CONVERTER(0)) dut_nc_u (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(nc_rdata), .pm_dac_auto_on(auto_on[7]), .converter_auto_on(auto_on[6]),
        .monitor_adc_auto_on(auto_on[5]), .dc_bias_auto_on(auto_on[4]),
        .line_circuit_auto_on(auto_on[3]), .adc_auto_on(auto_on[2]), .dac_auto_on(auto_on[1]),
        .gm_amp_auto_on(auto_on[0]), .timer_events(ev_t), .line_alarm_events(ev_l),
        .pm_dac_pwr(), .converter_pwr(nc_conv), .monitor_adc_pwr(), .dc_bias_pwr(),
        .line_circuit_pwr(), .adc_pwr(), .dac_pwr(), .gm_amp_pwr(), .irq_out());
    // ==========================================================
    // helpers
    task chk(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            host_u.rd(a, rd_val);
            chk(rd_val, e);
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    // one-cycle event pulse that the flag captures on its edge, then one edge for irq_out to follow
    task pulse(input [7:0] t, input [7:0] l);
        begin
            ev_t = t;
            ev_l = l;
            cyc(1);
            ev_t = 8'h00;
            ev_l = 8'h00;
            cyc(1);
        end
    endtask
    task final_report;
        begin
            if (fail_count == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // ==========================================================
    // scenarios
    task t_reset;
        begin
            rd_chk(8'h0e, 8'h10);
            rd_chk(8'h0f, 8'h00);
            rd_chk(8'h12, 8'h00);
            rd_chk(8'h13, 8'h00);
            rd_chk(8'h15, 8'h00);
            rd_chk(8'h16, 8'h00);
            host_u.wr(8'h20, 8'ha5);
            rd_chk(8'h20, 8'h00);
        end
    endtask
    task t_force;
        begin
            auto_on = 8'h7f;
            host_u.wr(8'h0e, 8'hff);
            rd_chk(8'h0e, 8'h3b);
            chk(pwr, 8'h87);
            host_u.wr(8'h0e, 8'h00);
            cyc(1);
            chk(pwr, 8'h7f);
            chk(nc_rdata, 8'h10);
            chk({7'h00, nc_conv}, 8'h00);
        end
    endtask
    task t_manual;
        begin
            auto_on = 8'h00;
            host_u.wr(8'h0f, 8'hff);
            rd_chk(8'h0f, 8'h3f);
            chk(pwr, 8'h07);
            auto_on = 8'hff;
            host_u.wr(8'h0f, 8'h2a);
            cyc(1);
            chk(pwr, 8'hf8);
            auto_on = 8'h00;
            host_u.wr(8'h0f, 8'h15);
            cyc(1);
            chk(pwr, 8'h00);
            // a write while the enable is low must leave the register untouched
            clk_en = 1'b0;
            host_u.wr(8'h0f, 8'h3f);
            clk_en = 1'b1;
            rd_chk(8'h0f, 8'h15);
        end
    endtask
    task t_irq;
        begin
            host_u.wr(8'h15, 8'h01);
            pulse(8'h81, 8'h00);
            rd_chk(8'h12, 8'h81);
            chk({7'h00, irq_out}, 8'h01);
            host_u.wr(8'h12, 8'h80);
            rd_chk(8'h12, 8'h01);
            chk({7'h00, irq_out}, 8'h01);
            host_u.wr(8'h12, 8'h01);
            rd_chk(8'h12, 8'h00);
            chk({7'h00, irq_out}, 8'h00);
            pulse(8'h00, 8'hff);
            rd_chk(8'h13, 8'hff);
            chk({7'h00, irq_out}, 8'h00);
            host_u.wr(8'h16, 8'hff);
            cyc(1);
            chk({7'h00, irq_out}, 8'h01);
            ev_l = 8'h01;
            host_u.wr(8'h13, 8'hff);
            ev_l = 8'h00;
            rd_chk(8'h13, 8'h01);
            host_u.wr(8'h13, 8'h01);
            cyc(1);
            chk({7'h00, irq_out}, 8'h00);
        end
    endtask
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        t_reset;
        t_force;
        t_manual;
        t_irq;
        final_report;
    end
endmodule

// file: logic/porb_defines.vh
// register offsets, field positions and reset values of the power and interrupt bank
`ifndef PORB_DEFINES_VH
`define PORB_DEFINES_VH
`define PORB_ADDR_W         8
`define PORB_OFS_PWR_A      8'h0e
`define PORB_OFS_PWR_B      8'h0f
`define PORB_OFS_IRQ_A      8'h12
`define PORB_OFS_IRQ_B      8'h13
`define PORB_OFS_IEN_A      8'h15
`define PORB_OFS_IEN_B      8'h16
`define PORB_RST_PWR_A      8'h10
`define PORB_RST_PWR_B      8'h00
`define PORB_RST_IRQ        8'h00
`define PORB_RST_IEN        8'h00
`define PORB_PWR_A_MASK     8'h3b
`define PORB_PWR_B_MASK     8'h3f
`define PORB_BIT_PM_ON      5
`define PORB_BIT_CONV_OFF   4
`define PORB_BIT_MON_OFF    3
`define PORB_BIT_BIAS_OFF   1
`define PORB_BIT_LINE_OFF   0
`define PORB_BIT_ADC_MAN    5
`define PORB_BIT_ADC_ON     4
`define PORB_BIT_DAC_MAN    3
`define PORB_BIT_DAC_ON     2
`define PORB_BIT_GM_MAN     1
`define PORB_BIT_GM_ON      0
`endif

// file: logic/porb_manual_pwr.v
// resolves manual or automatic power for one analog block
`timescale 1ns/1ps
module porb_manual_pwr (
    input  wire manual_sel,
    input  wire manual_on,
    input  wire auto_on,
    output wire power_on
);
    // =========================================================
    // the on bit is ignored entirely while in automatic mode
    assign power_on = manual_sel ? manual_on : auto_on;
endmodule

// file: logic/porb_pend_reg.v
// one eight-bit pending-flag register with write-one-to-clear and set priority
`timescale 1ns/1ps
`include "porb_defines.vh"
module porb_pend_reg (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire [7:0] event_in,
    input  wire       clr_wr,
    input  wire [7:0] clr_data,
    output reg  [7:0] pend_reg
);
    wire [7:0] pend_next;
    genvar i;
    // =========================================================
    // per-bit flag: set beats clear so a coincident event survives
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign pend_next[i] = event_in[i] |
                                  (pend_reg[i] & ~(clr_wr & clr_data[i]));
        end
    endgenerate
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= `PORB_RST_IRQ;
        end else if (clk_en) begin
            pend_reg <= pend_next;
        end
    end
endmodule

// file: logic/porb_regs.v
// power override and interrupt pending register bank
`timescale 1ns/1ps
`include "porb_defines.vh"
module porb_regs #(
    parameter HAS_CONVERTER = 1
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       pm_dac_auto_on,
    input  wire       converter_auto_on,
    input  wire       monitor_adc_auto_on,
    input  wire       dc_bias_auto_on,
    input  wire       line_circuit_auto_on,
    input  wire       adc_auto_on,
    input  wire       dac_auto_on,
    input  wire       gm_amp_auto_on,
    input  wire [7:0] timer_events,
    input  wire [7:0] line_alarm_events,
    output reg        pm_dac_pwr,
    output reg        converter_pwr,
    output reg        monitor_adc_pwr,
    output reg        dc_bias_pwr,
    output reg        line_circuit_pwr,
    output reg        adc_pwr,
    output reg        dac_pwr,
    output reg        gm_amp_pwr,
    output reg        irq_out
);
    reg  [7:0] power_override_ctrl_a_reg;
    reg  [7:0] power_manual_ctrl_b_reg;
    reg  [7:0] timer_irq_enable_reg;
    reg  [7:0] line_alarm_irq_enable_reg;
    reg  [7:0] pwr_a_next;
    reg  [7:0] rdata_next;
    wire [7:0] timer_irq_pending;
    wire [7:0] line_alarm_irq_pending;
    wire       adc_res;
    wire       dac_res;
    wire       gm_res;
    wire       wr_pwr_a;
    wire       wr_pwr_b;
    wire       wr_irq_a;
    wire       wr_irq_b;
    wire       wr_ien_a;
    wire       wr_ien_b;
    wire       irq_next;
    wire       conv_off_bit;

    // =========================================================
    // address decode, writes take effect in the same enabled cycle
    assign wr_pwr_a = reg_wr & (reg_addr == `PORB_OFS_PWR_A);
    assign wr_pwr_b = reg_wr & (reg_addr == `PORB_OFS_PWR_B);
    assign wr_irq_a = reg_wr & (reg_addr == `PORB_OFS_IRQ_A);
    assign wr_irq_b = reg_wr & (reg_addr == `PORB_OFS_IRQ_B);
    assign wr_ien_a = reg_wr & (reg_addr == `PORB_OFS_IEN_A);
    assign wr_ien_b = reg_wr & (reg_addr == `PORB_OFS_IEN_B);

    // =========================================================
    // first power register; converter bit pinned high when absent
    always @* begin
        pwr_a_next = power_override_ctrl_a_reg;
        if (wr_pwr_a) begin
            pwr_a_next = reg_wdata & `PORB_PWR_A_MASK;
        end
        if (HAS_CONVERTER == 0) begin
            pwr_a_next[`PORB_BIT_CONV_OFF] = 1'b1;
        end
    end

    // =========================================================
    // writable control and enable registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_override_ctrl_a_reg <= `PORB_RST_PWR_A;
            power_manual_ctrl_b_reg   <= `PORB_RST_PWR_B;
            timer_irq_enable_reg      <= `PORB_RST_IEN;
            line_alarm_irq_enable_reg <= `PORB_RST_IEN;
        end else if (clk_en) begin
            power_override_ctrl_a_reg <= pwr_a_next;
            if (wr_pwr_b) begin
                power_manual_ctrl_b_reg <= reg_wdata & `PORB_PWR_B_MASK;
            end
            if (wr_ien_a) begin
                timer_irq_enable_reg <= reg_wdata;
            end
            if (wr_ien_b) begin
                line_alarm_irq_enable_reg <= reg_wdata;
            end
        end
    end

    // =========================================================
    // pending flags: timers, then alarms/loop close/ring trip
    porb_pend_reg u_timer_pend (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .event_in (timer_events),
        .clr_wr   (wr_irq_a),
        .clr_data (reg_wdata),
        .pend_reg (timer_irq_pending)
    );
    porb_pend_reg u_alarm_pend (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .event_in (line_alarm_events),
        .clr_wr   (wr_irq_b),
        .clr_data (reg_wdata),
        .pend_reg (line_alarm_irq_pending)
    );

    // =========================================================
    // manual/automatic selection for the three switched blocks
    porb_manual_pwr u_adc (
        .manual_sel (power_manual_ctrl_b_reg[`PORB_BIT_ADC_MAN]),
        .manual_on  (power_manual_ctrl_b_reg[`PORB_BIT_ADC_ON]),
        .auto_on    (adc_auto_on),
        .power_on   (adc_res)
    );
    porb_manual_pwr u_dac (
        .manual_sel (power_manual_ctrl_b_reg[`PORB_BIT_DAC_MAN]),
        .manual_on  (power_manual_ctrl_b_reg[`PORB_BIT_DAC_ON]),
        .auto_on    (dac_auto_on),
        .power_on   (dac_res)
    );
    porb_manual_pwr u_gm (
        .manual_sel (power_manual_ctrl_b_reg[`PORB_BIT_GM_MAN]),
        .manual_on  (power_manual_ctrl_b_reg[`PORB_BIT_GM_ON]),
        .auto_on    (gm_amp_auto_on),
        .power_on   (gm_res)
    );

    assign conv_off_bit = power_override_ctrl_a_reg[`PORB_BIT_CONV_OFF];

    // =========================================================
    // interrupt: any flag whose enable is set
    assign irq_next = |(timer_irq_pending & timer_irq_enable_reg) |
                      |(line_alarm_irq_pending & line_alarm_irq_enable_reg);

    // =========================================================
    // registered power outputs, so auto inputs see one cycle of latency
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_dac_pwr       <= 1'b0;
            converter_pwr    <= 1'b0;
            monitor_adc_pwr  <= 1'b0;
            dc_bias_pwr      <= 1'b0;
            line_circuit_pwr <= 1'b0;
            adc_pwr          <= 1'b0;
            dac_pwr          <= 1'b0;
            gm_amp_pwr       <= 1'b0;
            irq_out          <= 1'b0;
        end else if (clk_en) begin
            pm_dac_pwr       <= power_override_ctrl_a_reg[`PORB_BIT_PM_ON] |
                                pm_dac_auto_on;
            converter_pwr    <= ~conv_off_bit & converter_auto_on;
            monitor_adc_pwr  <= ~power_override_ctrl_a_reg[`PORB_BIT_MON_OFF] &
                                monitor_adc_auto_on;
            dc_bias_pwr      <= ~power_override_ctrl_a_reg[`PORB_BIT_BIAS_OFF] &
                                dc_bias_auto_on;
            line_circuit_pwr <= ~power_override_ctrl_a_reg[`PORB_BIT_LINE_OFF] &
                                line_circuit_auto_on;
            adc_pwr          <= adc_res;
            dac_pwr          <= dac_res;
            gm_amp_pwr       <= gm_res;
            irq_out          <= irq_next;
        end
    end

    // =========================================================
    // read mux; reserved bits and unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `PORB_OFS_PWR_A: rdata_next = power_override_ctrl_a_reg;
            `PORB_OFS_PWR_B: rdata_next = power_manual_ctrl_b_reg;
            `PORB_OFS_IRQ_A: rdata_next = timer_irq_pending;
            `PORB_OFS_IRQ_B: rdata_next = line_alarm_irq_pending;
            `PORB_OFS_IEN_A: rdata_next = timer_irq_enable_reg;
            `PORB_OFS_IEN_B: rdata_next = line_alarm_irq_enable_reg;
            default:         rdata_next = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= rdata_next;
        end
    end
endmodule
